// ### core/irxmf_filter.sv
`timescale 1ns/100ps
// Isochronous receive match filter for four receive contexts.
module irxmf_filter
    import irxmf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [DW-1:0] pwdata,
    output logic [DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [DW-1:0] cycle_timer,
    input wire logic [NCTX-1:0] wait_sync,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [DW-1:0] in_data,
    input wire logic in_first,
    input wire logic in_last,
    output logic out_valid,
    input wire logic out_ready,
    output logic [DW-1:0] out_data,
    output logic [CTXW-1:0] out_ctx,
    output logic out_last
);
    logic [DW-1:0] match_v [NCTX];
    logic [NCTX-1:0] run_v, gate_v, open_v, hit_v, wr_match, wr_ctrl, sel_match, sel_ctrl;
    logic acc, setup;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [DW-1:0] prdata_q, prdata_d;
    logic [1:0] tag;
    logic [5:0] chan;
    logic [3:0] sy;

    // Split the header quadlet into its fields.
    assign tag = in_data[H_TAG_HI:H_TAG_LO];
    assign chan = in_data[H_CHAN_HI:H_CHAN_LO];
    assign sy = in_data[H_SY_HI:H_SY_LO];

    // A write lands only at the edge where the master sees pready high.
    assign acc = psel && penable && pready_q;
    assign setup = psel && penable && !pready_q;

    // Per-context registers and acceptance test.
    for (genvar i = 0; i < NCTX; i++) begin : g_ctx // RL14
        logic [DW-1:0] match_q, match_d;
        logic run_q, run_d, gate_q, gate_d, open_q, open_d;
        logic tag_ok, sync_ok;

        assign sel_match[i] = (paddr == AW'(MATCH_BASE + AW'(i) * CTX_STRIDE));
        assign sel_ctrl[i] = (paddr == AW'(CTRL_BASE + AW'(i) * CTX_STRIDE));
        assign wr_match[i] = acc && pwrite && sel_match[i];
        assign wr_ctrl[i] = acc && pwrite && sel_ctrl[i];

        // Next values; receive stays shut until the run bit is set.
        always_comb begin
            match_d = match_q;
            run_d = run_q;
            gate_d = gate_q;
            open_d = open_q;
            if (wr_match[i]) begin
                match_d = pwdata & MATCH_WMASK; // RL5 RL13 RL6
            end
            if (wr_ctrl[i]) begin
                run_d = pwdata[C_RUN];
                gate_d = pwdata[C_GATE];
            end
            if (!run_q) begin
                open_d = 1'b0; // RL15
            end else if (!gate_q) begin
                open_d = 1'b1;
            end else if (cycle_timer[T_HI:T_LO] == match_q[M_START_HI:M_START_LO]) begin
                open_d = 1'b1; // RL7
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                match_q <= MATCH_RESET;
                run_q <= 1'b0;
                gate_q <= 1'b0;
                open_q <= 1'b0;
            end else begin
                match_q <= match_d;
                run_q <= run_d;
                gate_q <= gate_d;
                open_q <= open_d;
            end
        end

        // Tag test; the marker screen only narrows tag 01b.
        always_comb begin
            case (tag)
                TAG_11: tag_ok = match_q[M_LABEL_THREE_ACCEPT]; // RL1 RL10
                TAG_10: tag_ok = match_q[M_LABEL_TWO_ACCEPT]; // RL2 RL10
                TAG_01: tag_ok = match_q[M_LABEL_ONE_ACCEPT] && (!match_q[M_SCREEN]
                    || sy[H_SY_HI:H_SY_HI-1] == SY_TOP_ZERO); // RL3 RL9 RL11
                default: tag_ok = match_q[M_LABEL_ZERO_ACCEPT]; // RL4 RL10
            endcase
        end

        assign sync_ok = !wait_sync[i] || (sy == match_q[M_SYNC_HI:M_SYNC_LO]); // RL8
        assign hit_v[i] = run_q && open_q && tag_ok && sync_ok
            && (chan == match_q[M_LANE_HI:M_LANE_LO]); // RL12 RL15
        assign match_v[i] = match_q;
        assign run_v[i] = run_q;
        assign gate_v[i] = gate_q;
        assign open_v[i] = open_q;
    end

    // Register read mux and unmapped-address error, prepared one cycle ahead.
    always_comb begin
        prdata_d = '0;
        pslverr_d = 1'b1;
        for (int k = 0; k < NCTX; k++) begin
            if (sel_match[k]) begin
                prdata_d = match_v[k];
                pslverr_d = 1'b0;
            end
            if (sel_ctrl[k]) begin
                prdata_d[C_RUN] = run_v[k];
                prdata_d[C_GATE] = gate_v[k];
                prdata_d[C_OPEN] = open_v[k];
                pslverr_d = 1'b0;
            end
        end
        if (!setup) begin
            prdata_d = prdata_q;
            pslverr_d = 1'b0;
        end
        pready_d = setup;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // Packet path state.
    irxmf_state_t st_q, st_d;
    logic [CTXW-1:0] ctx_q, ctx_d, pick;
    logic any_hit, take, hdr_take, push, buf_ready;
    logic [PW-1:0] buf_out;

    // Lowest numbered hitting context wins when several match.
    always_comb begin
        pick = '0;
        for (int k = NCTX - 1; k >= 0; k--) begin
            if (hit_v[k]) begin
                pick = CTXW'(k);
            end
        end
    end

    assign any_hit = |hit_v;
    assign take = in_valid && buf_ready;
    assign hdr_take = take && st_q == IRXMF_IDLE;

    // A rejected header steers the rest of its packet into the drop state.
    always_comb begin
        st_d = st_q;
        ctx_d = ctx_q;
        push = 1'b0;
        case (st_q)
            IRXMF_IDLE: begin
                if (take && in_first) begin
                    if (any_hit) begin
                        push = 1'b1;
                        ctx_d = pick;
                        st_d = in_last ? IRXMF_IDLE : IRXMF_PASS;
                    end else begin
                        st_d = in_last ? IRXMF_IDLE : IRXMF_DROP; // RL16
                    end
                end
            end
            IRXMF_PASS: begin
                push = take;
                if (take && in_last) begin
                    st_d = IRXMF_IDLE;
                end
            end
            IRXMF_DROP: begin
                if (take && in_last) begin
                    st_d = IRXMF_IDLE; // RL16
                end
            end
            default: st_d = IRXMF_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= IRXMF_IDLE;
            ctx_q <= '0;
        end else begin
            st_q <= st_d;
            ctx_q <= ctx_d;
        end
    end

    // Dropped words still wait on the buffer, trading a little throughput for one ready flop.
    irxmf_buf #(.W(PW)) u_buf (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(push),
        .in_ready(buf_ready),
        .in_data({ctx_d, in_last, in_data}),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(buf_out)
    );

    assign in_ready = buf_ready;
    assign out_ctx = buf_out[PW-1:PW-CTXW];
    assign out_last = buf_out[DW];
    assign out_data = buf_out[DW-1:0];

    // Checks beside the logic they guard.
    property p_rsvd27;
        @(posedge pclk) disable iff (!presetn) pready_q |-> !prdata_q[M_RSVD_HI];
    endproperty
    a_rsvd27: assert property (p_rsvd27) else $error("reserved bit 27 read as one"); // RL5

    property p_rsvd7;
        @(posedge pclk) disable iff (!presetn)
        (setup && sel_match[0]) |=> (!prdata_q[M_RSVD_LO] && pready_q);
    endproperty
    a_rsvd7: assert property (p_rsvd7) else $error("reserved bit 7 read as one"); // RL13

    property p_start;
        @(posedge pclk) disable iff (!presetn)
        (wr_match[0]) |=> (match_v[0][M_START_HI:M_START_LO]
            == $past(pwdata[M_START_HI:M_START_LO]));
    endproperty
    a_start: assert property (p_start) else $error("start value not stored"); // RL6

    property p_open;
        @(posedge pclk) disable iff (!presetn)
        (run_v[1] && gate_v[1] && !open_v[1] && !wr_ctrl[1]
            && cycle_timer[T_HI:T_LO] != match_v[1][M_START_HI:M_START_LO])
            |=> !open_v[1];
    endproperty
    a_open: assert property (p_open) else $error("context opened before start"); // RL7

    property p_run;
        @(posedge pclk) disable iff (!presetn)
        (hdr_take && in_first && any_hit) |-> (run_v[pick] && open_v[pick]);
    endproperty
    a_run: assert property (p_run) else $error("stopped context accepted"); // RL15

    property p_lane;
        @(posedge pclk) disable iff (!presetn)
        (hdr_take && in_first && any_hit)
            |-> chan == match_v[pick][M_LANE_HI:M_LANE_LO];
    endproperty
    a_lane: assert property (p_lane) else $error("channel mismatch accepted"); // RL12

    property p_screen;
        @(posedge pclk) disable iff (!presetn)
        (hdr_take && in_first && any_hit && tag == TAG_01 && match_v[pick][M_SCREEN])
            |-> sy[H_SY_HI:H_SY_HI-1] == SY_TOP_ZERO;
    endproperty
    a_screen: assert property (p_screen) else $error("screened tag 01b accepted"); // RL9

    property p_sync;
        @(posedge pclk) disable iff (!presetn)
        (hdr_take && in_first && any_hit && wait_sync[pick])
            |-> sy == match_v[pick][M_SYNC_HI:M_SYNC_LO];
    endproperty
    a_sync: assert property (p_sync) else $error("sync mismatch accepted"); // RL8

    property p_drop;
        @(posedge pclk) disable iff (!presetn)
        (hdr_take && in_first && !any_hit && !in_last) |=> (st_q == IRXMF_DROP) ##0 !push;
    endproperty
    a_drop: assert property (p_drop) else $error("rejected packet not dropped"); // RL16
endmodule // irxmf_filter

// ### core/irxmf_pkg.sv
// Operation
// RL1 - Highest label enable set: accept packets carrying tag 11b.
// RL2 - Second label enable set: accept packets carrying tag 10b.
// RL3 - Label-one enable set: accept tag 01b packets, subject to the marker screen.
// RL4 - Label-zero enable set: accept packets carrying tag 00b.
// RL5 - Bit 27 of the match settings always reads as zero.
// RL6 - Start value is 15 bits: two seconds bits above a 13-bit period count.
// RL7 - With start gate on, receive opens when timer bits equal the start value.
// RL8 - While the descriptor waits on sync, packet sync must equal the sync field.
// RL9 - Marker screen plus label-one: tag 01b accepted only when sync bits 3:2 are 00b.
// RL10 - Marker screen never affects packets with tags other than 01b.
// RL11 - Marker screen clear: the four label enables alone decide acceptance.
// RL12 - Only packets whose channel equals the 6-bit lane id are accepted.
// RL13 - Bit 7 of the match settings always reads as zero.
// RL14 - Four independent receive contexts, each with its own match settings.
// RL15 - Filtering of a context takes effect only once its run bit is set.
// RL16 - A packet failing any enabled criterion is discarded, never passed on.
package irxmf_pkg;
    localparam int NCTX = 4;
    localparam int CTXW = 2;
    localparam int AW = 16;
    localparam int DW = 32;

    // Register map, byte addresses, one block of registers per context.
    localparam logic [AW-1:0] CTRL_BASE = 16'h4100;
    localparam logic [AW-1:0] MATCH_BASE = 16'h410C;
    localparam logic [AW-1:0] CTX_STRIDE = 16'h0020;

    // Match settings layout.
    localparam int M_LABEL_THREE_ACCEPT = 31;
    localparam int M_LABEL_TWO_ACCEPT = 30;
    localparam int M_LABEL_ONE_ACCEPT = 29;
    localparam int M_LABEL_ZERO_ACCEPT = 28;
    localparam int M_RSVD_HI = 27;
    localparam int M_START_HI = 26;
    localparam int M_START_LO = 12;
    localparam int M_SYNC_HI = 11;
    localparam int M_SYNC_LO = 8;
    localparam int M_RSVD_LO = 7;
    localparam int M_SCREEN = 6;
    localparam int M_LANE_HI = 5;
    localparam int M_LANE_LO = 0;
    localparam logic [DW-1:0] MATCH_WMASK = 32'hF7FF_FF7F;
    localparam logic [DW-1:0] MATCH_RESET = 32'h0000_0000;

    // Context control layout.
    localparam int C_GATE = 29;
    localparam int C_RUN = 15;
    localparam int C_OPEN = 10;

    // Cycle timer bits compared with the start value.
    localparam int T_HI = 26;
    localparam int T_LO = 12;

    // Isochronous header quadlet layout.
    localparam int H_TAG_HI = 15;
    localparam int H_TAG_LO = 14;
    localparam int H_CHAN_HI = 13;
    localparam int H_CHAN_LO = 8;
    localparam int H_SY_HI = 3;
    localparam int H_SY_LO = 0;
    localparam logic [1:0] TAG_11 = 2'h3;
    localparam logic [1:0] TAG_10 = 2'h2;
    localparam logic [1:0] TAG_01 = 2'h1;
    localparam logic [1:0] SY_TOP_ZERO = 2'h0;

    // Buffer payload: context, last flag, data word.
    localparam int PW = CTXW + 1 + DW;

    typedef enum logic [1:0] {
        IRXMF_IDLE,
        IRXMF_PASS,
        IRXMF_DROP
    } irxmf_state_t;
endpackage

// ### core/irxmf_buf.sv
`timescale 1ns/100ps
// Two-entry buffer; both handshake outputs come straight from flip-flops.
module irxmf_buf
    import irxmf_pkg::*;
#(
    parameter int W = PW
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] head_q, head_d, tail_q, tail_d;
    logic [1:0] cnt_q, cnt_d;
    logic rdy_q, rdy_d, vld_q, vld_d;
    logic push, pop;

    // Ready is registered from the count, so a push can never land on a full buffer.
    always_comb begin
        push = in_valid && rdy_q;
        pop = vld_q && out_ready;
        head_d = head_q;
        tail_d = tail_q;
        cnt_d = cnt_q;
        if (pop) begin
            if (cnt_q == 2'd2) begin
                head_d = tail_q;
                if (push) begin
                    tail_d = in_data;
                end
            end else if (push) begin
                head_d = in_data;
            end
        end else if (push) begin
            if (cnt_q == 2'd0) begin
                head_d = in_data;
            end else begin
                tail_d = in_data;
            end
        end
        cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
        rdy_d = (cnt_d != 2'd2);
        vld_d = (cnt_d != 2'd0);
    end

    // Register stage.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            head_q <= '0;
            tail_q <= '0;
            cnt_q <= 2'd0;
            rdy_q <= 1'b0;
            vld_q <= 1'b0;
        end else begin
            head_q <= head_d;
            tail_q <= tail_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
            vld_q <= vld_d;
        end
    end

    assign in_ready = rdy_q;
    assign out_valid = vld_q;
    assign out_data = head_q;
endmodule // irxmf_buf

// ### tb/irxmf_src.sv
`timescale 1ns/100ps
// Isochronous packet words, single or multi-quadlet, as they arrive from the PHY side.
module irxmf_src (
    input wire logic pclk,
    input wire logic in_ready,
    output logic in_valid,
    output logic [31:0] in_data,
    output logic in_first,
    output logic in_last
);
    // Nothing is offered at time zero.
    initial begin
        in_valid = 1'b0;
        in_data = 32'h0000_0000;
        in_first = 1'b0;
        in_last = 1'b0;
    end

    // A word is held until the rising edge that sees ready, and is taken at that edge.
    task automatic send_word(input logic [31:0] d, input logic f, input logic l);
        int n;
        n = 0;
        in_valid <= 1'b1;
        in_data <= d;
        in_first <= f;
        in_last <= l;
        forever begin
            @(posedge pclk);
            n++;
            if (in_ready === 1'b1 || n > 40) break;
        end
        if (n > 40) begin
            irxmf_filter_tb.failures++;
            irxmf_filter_tb.end_of_test();
        end
    endtask

    // Single-quadlet packet: the header is also the last word.
    task automatic send(input logic [31:0] d);
        send_word(d, 1'b1, 1'b1);
    endtask

    // Released lines show the inverse of the last word, so no stale value looks valid.
    task automatic idle();
        in_valid <= 1'b0;
        in_first <= 1'b0;
        in_last <= 1'b0;
        in_data <= ~in_data;
    endtask
endmodule // irxmf_src

// ### tb/irxmf_filter_tb.sv
`timescale 1ns/100ps
// Self-checking bench for the receive match filter.
module irxmf_filter_tb;
    import irxmf_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [AW-1:0] paddr;
    logic [DW-1:0] pwdata, prdata, cycle_timer, in_data, out_data, rx_data, q;
    logic [NCTX-1:0] wait_sync;
    logic in_valid, in_ready, in_first, in_last, out_valid, out_ready, out_last, rx_last;
    logic [CTXW-1:0] out_ctx, rx_ctx;
    int failures = 0;
    int cmp_count = 0;
    int rx_n = 0;
    int n_keep = 0;

    irxmf_filter DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cycle_timer(cycle_timer), .wait_sync(wait_sync),
        .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .in_first(in_first),
        .in_last(in_last), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .out_ctx(out_ctx), .out_last(out_last));
    irxmf_src src (.pclk(pclk), .in_ready(in_ready), .in_valid(in_valid),
        .in_data(in_data), .in_first(in_first), .in_last(in_last));

    // Free-running 10 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // The sink counts every word that leaves and keeps only the last, so drops show as a missing count.
    always @(posedge pclk) begin
        if (out_valid && out_ready) begin
            rx_n <= rx_n + 1;
            rx_ctx <= out_ctx;
            rx_data <= out_data;
            rx_last <= out_last;
        end
    end

    task automatic end_of_test();
        if (failures == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; an idle edge first keeps back-to-back calls race free.
    task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Read data and error are taken only at the edge that samples pready high.
        forever begin
            @(posedge pclk);
            n++;
            if (pready === 1'b1) begin
                q = prdata;
                err = pslverr;
                break;
            end
            if (n > 20) break;
        end
        if (n > 20) begin
            failures++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [DW-1:0] hdr(input logic [1:0] t, input logic [5:0] ch,
        input logic [3:0] sy);
        hdr = 32'h0000_0000;
        hdr[H_TAG_HI:H_TAG_LO] = t;
        hdr[H_CHAN_HI:H_CHAN_LO] = ch;
        hdr[H_SY_HI:H_SY_LO] = sy;
    endfunction

    // Sends one packet and checks whether it came out, and for which context.
    task automatic pkt(input string what, input logic [DW-1:0] h, input int hit,
        input logic [CTXW-1:0] c);
        int n0;
        n0 = rx_n;
        src.send(h);
        src.idle();
        repeat (6) @(posedge pclk);
        check(what, DW'(rx_n - n0), DW'(hit));
        if (hit == 1) begin
            check({what, " ctx"}, DW'(rx_ctx), DW'(c));
            check({what, " data"}, rx_data, h);
            check({what, " last"}, DW'(rx_last), 32'h0000_0001);
        end
    endtask

    // Main sequence: registers, each tag, channel, screen, sync, start gate, stall.
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        cycle_timer = 32'h0000_0000;
        wait_sync = 4'h0;
        out_ready = 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 16'h410C, 32'h0000_0000);
        check("match reset", q, 32'h0000_0000);
        apb(1'b1, 16'h410C, 32'hFFFF_FFFF);
        apb(1'b0, 16'h410C, 32'h0000_0000);
        check("match readback", q, 32'hF7FF_FF7F);
        apb(1'b0, 16'h4000, 32'h0000_0000);
        check("unmapped err", DW'(err), 32'h0000_0001);
        apb(1'b1, 16'h410C, 32'h8000_0005);
        pkt("before run", hdr(2'h3, 6'd5, 4'h0), 0, 2'd0);
        apb(1'b1, 16'h4100, 32'h0000_8000);
        apb(1'b0, 16'h4100, 32'h0000_0000);
        check("ctrl open", q, 32'h0000_8400);
        for (int t = 0; t < 4; t++) begin
            apb(1'b1, 16'h410C, (32'h1000_0000 << t) | 32'h0000_0005);
            pkt("tag on", hdr(2'(t), 6'd5, 4'h0), 1, 2'd0);
            pkt("tag off", hdr(2'(t + 1), 6'd5, 4'h0), 0, 2'd0);
        end
        apb(1'b1, 16'h410C, 32'hF000_0005);
        pkt("lane miss", hdr(2'h0, 6'd6, 4'h0), 0, 2'd0);
        apb(1'b1, 16'h410C, 32'hF000_0045);
        pkt("screen drop", hdr(2'h1, 6'd5, 4'h4), 0, 2'd0);
        pkt("screen pass", hdr(2'h1, 6'd5, 4'h3), 1, 2'd0);
        pkt("screen other", hdr(2'h2, 6'd5, 4'hC), 1, 2'd0);
        apb(1'b1, 16'h410C, 32'hF000_0505);
        wait_sync <= 4'h1;
        pkt("sync hit", hdr(2'h0, 6'd5, 4'h5), 1, 2'd0);
        pkt("sync miss", hdr(2'h0, 6'd5, 4'h6), 0, 2'd0);
        wait_sync <= 4'h0;
        apb(1'b1, 16'h414C, 32'h4123_4009);
        apb(1'b1, 16'h4140, 32'h2000_8000);
        pkt("gate shut", hdr(2'h2, 6'd9, 4'h0), 0, 2'd0);
        cycle_timer <= 32'h0123_4000;
        repeat (3) @(posedge pclk);
        cycle_timer <= 32'h0000_0000;
        apb(1'b0, 16'h4140, 32'h0000_0000);
        check("ctrl2 open", q, 32'h2000_8400);
        pkt("gate open", hdr(2'h2, 6'd9, 4'h0), 1, 2'd2);
        // Two-word packets: the body follows its header through, or is dropped with it.
        n_keep = rx_n;
        src.send_word(hdr(2'h0, 6'd5, 4'h0), 1'b1, 1'b0);
        src.send_word(32'h1234_5678, 1'b0, 1'b1);
        src.idle();
        repeat (6) @(posedge pclk);
        check("long count", DW'(rx_n - n_keep), 32'h0000_0002);
        check("long ctx", DW'(rx_ctx), 32'h0000_0000);
        check("long data", rx_data, 32'h1234_5678);
        check("long last", DW'(rx_last), 32'h0000_0001);
        n_keep = rx_n;
        src.send_word(hdr(2'h0, 6'd7, 4'h0), 1'b1, 1'b0);
        src.send_word(32'h1234_5678, 1'b0, 1'b1);
        src.idle();
        repeat (6) @(posedge pclk);
        check("long drop", DW'(rx_n - n_keep), 32'h0000_0000);
        out_ready <= 1'b0;
        n_keep = rx_n;
        src.send(hdr(2'h0, 6'd5, 4'h1));
        src.send(hdr(2'h0, 6'd5, 4'h2));
        src.idle();
        repeat (3) @(posedge pclk);
        check("full ready", DW'(in_ready), 32'h0000_0000);
        out_ready <= 1'b1;
        repeat (6) @(posedge pclk);
        check("drained", DW'(rx_n - n_keep), 32'h0000_0002);
        check("last word", rx_data, hdr(2'h0, 6'd5, 4'h2));
        end_of_test();
    end
endmodule // irxmf_filter_tb
